// ==== rtl/iqafe_pkg.sv ====
package iqafe_pkg;

    // Data widths
    localparam int RX_W = 8;
    localparam int TX_W = 10;
    localparam int MODE_W = 8;
    localparam int SER_BITS = 8;
    localparam int SER_CNT_W = 3;

    // Receive latency in half conversion-clock periods (5 and 5.5 cycles)
    localparam int RX_I_LAT_HALF = 10;
    localparam int RX_Q_LAT_HALF = 11;

    // Synchroniser layout: {tx_in_bus, ser_din, ser_cs_n, ser_clk, conv_clk}
    localparam int SYNC_W = TX_W + 4;
    localparam int SYNC_CONV = 0;
    localparam int SYNC_SCLK = 1;
    localparam int SYNC_CS_N = 2;
    localparam int SYNC_DIN = 3;
    localparam int SYNC_TX = 4;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 14'h3FFF;

    // Mode codes in the low three bits of the mode word
    localparam logic [2:0] MODE_SHUTDOWN = 3'h0;
    localparam logic [2:0] MODE_IDLE = 3'h1;
    localparam logic [2:0] MODE_RX = 3'h2;
    localparam logic [2:0] MODE_TX = 3'h3;
    localparam logic [2:0] MODE_XCVR = 3'h4;
    localparam logic [2:0] MODE_STANDBY = 3'h5;
    localparam logic [2:0] MODE_LAST = 3'h5;

    // Values after reset
    localparam logic [MODE_W-1:0] MODE_WORD_RESET = 8'h00;
    localparam logic [RX_W-1:0] RX_OUT_RESET = 8'h80;
    localparam logic [TX_W-1:0] TX_MIDSCALE = 10'h200;
    localparam logic [SER_CNT_W-1:0] SER_CNT_RESET = 3'h0;
    localparam logic [SER_CNT_W-1:0] SER_CNT_LAST = 3'h7;

    // Serial port states
    typedef enum logic [1:0] {
        SER_IDLE,
        SER_SHIFT,
        SER_HOLD
    } iqafe_ser_e;

    // One simultaneous receive sample
    typedef struct packed {
        logic [RX_W-1:0] i;
        logic [RX_W-1:0] q;
    } iqafe_rx_pair_s;

    // One transmit word pair
    typedef struct packed {
        logic [TX_W-1:0] i;
        logic [TX_W-1:0] q;
    } iqafe_tx_pair_s;

    // Power enables of the analog sections
    typedef struct packed {
        logic ref_en;
        logic clk_en;
        logic adc_en;
        logic dac_en;
    } iqafe_power_s;

    localparam iqafe_power_s POWER_RESET = 4'h0;

    // Two's complement quantizer result to offset binary
    function automatic logic [RX_W-1:0] iqafe_to_offset(input logic [RX_W-1:0] v);
        iqafe_to_offset = {~v[RX_W-1], v[RX_W-2:0]};
    endfunction : iqafe_to_offset

    // Mode code to section enables
    function automatic iqafe_power_s iqafe_decode(input logic [2:0] m);
        iqafe_power_s p;
        p = POWER_RESET;
        case (m)
            MODE_IDLE: begin
                p.ref_en = 1'b1;
                p.clk_en = 1'b1;
            end
            MODE_RX: begin
                p = 4'hE;
            end
            MODE_TX: begin
                p = 4'hD;
            end
            MODE_XCVR: begin
                p = 4'hF;
            end
            MODE_STANDBY: begin
                p.ref_en = 1'b1;
            end
            default: begin
                p = POWER_RESET;
            end
        endcase
        iqafe_decode = p;
    endfunction : iqafe_decode

endpackage : iqafe_pkg

// ==== rtl/iqafe_port.sv ====
// Contract
// - Sample I and Q together on rising edge
// - I word after rise, Q after fall
// - Latency five cycles I, five and half Q
// - Pipeline advances every half clock cycle
// - Receive words coded offset binary
// - Capture I on fall, Q on rise
// - Both DAC outputs update next rising edge
// - Transmit words are offset binary
// - 8-bit mode register, serial load only
// - Serial port works in every mode
// - Low three bits select six modes
// - Chip select low, MSB first, latch eight
// - Tri-state receive bus, resume last word
`timescale 1ns/10ps
`default_nettype none

module iqafe_port (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic conv_clk,
    input wire logic [iqafe_pkg::RX_W-1:0] rx_i_channel,
    input wire logic [iqafe_pkg::RX_W-1:0] rx_q_channel,
    output logic [iqafe_pkg::RX_W-1:0] rx_out_bus,
    output logic rx_out_oe,
    input wire logic [iqafe_pkg::TX_W-1:0] tx_in_bus,
    output iqafe_pkg::iqafe_tx_pair_s tx_out,
    output logic tx_update,
    input wire logic ser_clk,
    input wire logic ser_cs_n,
    input wire logic ser_din,
    output logic [iqafe_pkg::MODE_W-1:0] mode_word,
    output iqafe_pkg::iqafe_power_s power
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection

    logic [iqafe_pkg::SYNC_W-1:0] sync1_reg;
    logic [iqafe_pkg::SYNC_W-1:0] sync2_reg;
    logic [1:0] prev_reg;
    logic conv_rise;
    logic conv_fall;
    logic sclk_rise;
    logic cs_n_s;
    logic din_s;
    logic [iqafe_pkg::TX_W-1:0] tx_bus_s;

    // Two flops per pin, third stage only for the two clocks
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg <= iqafe_pkg::SYNC_RESET;
            sync2_reg <= iqafe_pkg::SYNC_RESET;
            prev_reg <= iqafe_pkg::SYNC_RESET[1:0];
        end else begin
            sync1_reg <= {tx_in_bus, ser_din, ser_cs_n, ser_clk, conv_clk};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg[1:0];
        end
    end

    // Rise between the previous and the current synchronised level
    function automatic logic rise_of(input logic cur, input logic prev);
        rise_of = cur & ~prev;
    endfunction : rise_of

    // Fall between the previous and the current synchronised level
    function automatic logic fall_of(input logic cur, input logic prev);
        fall_of = ~cur & prev;
    endfunction : fall_of

    // Edges seen on the synchronised copies only
    always_comb begin
        conv_rise = rise_of(sync2_reg[iqafe_pkg::SYNC_CONV], prev_reg[iqafe_pkg::SYNC_CONV]);
        conv_fall = fall_of(sync2_reg[iqafe_pkg::SYNC_CONV], prev_reg[iqafe_pkg::SYNC_CONV]);
        sclk_rise = rise_of(sync2_reg[iqafe_pkg::SYNC_SCLK], prev_reg[iqafe_pkg::SYNC_SCLK]);
    end

    // Data taps, same skew as the clock edges they travel with
    always_comb begin
        cs_n_s = sync2_reg[iqafe_pkg::SYNC_CS_N];
        din_s = sync2_reg[iqafe_pkg::SYNC_DIN];
        tx_bus_s = sync2_reg[iqafe_pkg::SYNC_TX +: iqafe_pkg::TX_W];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial port and mode register

    iqafe_pkg::iqafe_ser_e ser_state_reg;
    iqafe_pkg::iqafe_ser_e ser_state_next;
    logic [iqafe_pkg::MODE_W-1:0] shift_reg;
    logic [iqafe_pkg::MODE_W-1:0] shift_next;
    logic [iqafe_pkg::SER_CNT_W-1:0] cnt_reg;
    logic [iqafe_pkg::SER_CNT_W-1:0] cnt_next;
    logic [iqafe_pkg::MODE_W-1:0] mode_word_reg;
    logic [iqafe_pkg::MODE_W-1:0] mode_word_next;
    iqafe_pkg::iqafe_power_s power_reg;
    iqafe_pkg::iqafe_power_s power_next;
    logic [iqafe_pkg::MODE_W-1:0] word_in;

    // Shift, count eight bits, then latch a defined mode
    always_comb begin
        ser_state_next = ser_state_reg;
        shift_next = shift_reg;
        cnt_next = cnt_reg;
        mode_word_next = mode_word_reg;
        power_next = power_reg;
        word_in = {shift_reg[iqafe_pkg::MODE_W-2:0], din_s};
        // Port stays live whatever the mode
        case (ser_state_reg)
            iqafe_pkg::SER_IDLE: begin
                cnt_next = iqafe_pkg::SER_CNT_RESET;
                if (!cs_n_s) begin
                    ser_state_next = iqafe_pkg::SER_SHIFT;
                end
            end
            iqafe_pkg::SER_SHIFT: begin
                if (cs_n_s) begin
                    ser_state_next = iqafe_pkg::SER_IDLE;
                end else if (sclk_rise) begin
                    shift_next = word_in; // MSB first
                    cnt_next = 3'(cnt_reg + 3'h1);
                    if (cnt_reg == iqafe_pkg::SER_CNT_LAST) begin
                        ser_state_next = iqafe_pkg::SER_HOLD;
                        // Only the low bits decode; bad codes dropped
                        if (word_in[2:0] <= iqafe_pkg::MODE_LAST) begin
                            mode_word_next = word_in;
                            power_next = iqafe_pkg::iqafe_decode(word_in[2:0]);
                        end
                    end
                end
            end
            iqafe_pkg::SER_HOLD: begin
                // Extra clocks ignored until chip select rises
                if (cs_n_s) begin
                    ser_state_next = iqafe_pkg::SER_IDLE;
                end
            end
            default: begin
                ser_state_next = iqafe_pkg::SER_IDLE;
            end
        endcase
    end

    // Serial and mode registers
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ser_state_reg <= iqafe_pkg::SER_IDLE;
            shift_reg <= iqafe_pkg::MODE_WORD_RESET;
            cnt_reg <= iqafe_pkg::SER_CNT_RESET;
            mode_word_reg <= iqafe_pkg::MODE_WORD_RESET;
            power_reg <= iqafe_pkg::POWER_RESET;
        end else begin
            ser_state_reg <= ser_state_next;
            shift_reg <= shift_next;
            cnt_reg <= cnt_next;
            mode_word_reg <= mode_word_next;
            power_reg <= power_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive pipeline and multiplexed output

    iqafe_pkg::iqafe_rx_pair_s pipe_reg [iqafe_pkg::RX_Q_LAT_HALF];
    iqafe_pkg::iqafe_rx_pair_s pipe_next [iqafe_pkg::RX_Q_LAT_HALF];
    logic [iqafe_pkg::RX_W-1:0] rx_out_reg;
    logic [iqafe_pkg::RX_W-1:0] rx_out_next;
    logic rx_oe_reg;
    logic rx_oe_next;

    // Half-cycle delay line; output latch closes the latency
    always_comb begin
        pipe_next = pipe_reg;
        rx_out_next = rx_out_reg;
        rx_oe_next = power_reg.adc_en;
        if (power_reg.adc_en && (conv_rise || conv_fall)) begin
            for (int k = 1; k < iqafe_pkg::RX_Q_LAT_HALF; k++) begin
                pipe_next[k] = pipe_reg[k-1];
            end
            if (conv_rise) begin
                pipe_next[0] = {rx_i_channel, rx_q_channel};
                // I word after rise, 10 half cycles old
                rx_out_next = iqafe_pkg::iqafe_to_offset(
                    pipe_reg[iqafe_pkg::RX_I_LAT_HALF-1].i);
            end else begin
                // Q word after fall, 11 half cycles old
                rx_out_next = iqafe_pkg::iqafe_to_offset(
                    pipe_reg[iqafe_pkg::RX_Q_LAT_HALF-1].q);
            end
        end
    end

    // Latch keeps the last word while the bus floats
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int k = 0; k < iqafe_pkg::RX_Q_LAT_HALF; k++) begin
                pipe_reg[k] <= '0;
            end
            rx_out_reg <= iqafe_pkg::RX_OUT_RESET;
            rx_oe_reg <= 1'b0;
        end else begin
            pipe_reg <= pipe_next;
            rx_out_reg <= rx_out_next;
            rx_oe_reg <= rx_oe_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit capture and paired update

    // I word waiting for its Q partner
    logic [iqafe_pkg::TX_W-1:0] tx_i_hold_reg;
    logic [iqafe_pkg::TX_W-1:0] tx_i_hold_next;
    logic tx_i_valid_reg;
    logic tx_i_valid_next;

    // Captured pair waiting for the next rise
    iqafe_pkg::iqafe_tx_pair_s tx_pair_reg;
    iqafe_pkg::iqafe_tx_pair_s tx_pair_next;
    logic tx_pair_valid_reg;
    logic tx_pair_valid_next;

    // Pair on the converters and its pulse
    iqafe_pkg::iqafe_tx_pair_s tx_out_reg;
    iqafe_pkg::iqafe_tx_pair_s tx_out_next;
    logic tx_upd_reg;
    logic tx_upd_next;

    // Words pass unchanged as offset binary
    always_comb begin
        tx_i_hold_next = tx_i_hold_reg;
        tx_i_valid_next = tx_i_valid_reg;
        tx_pair_next = tx_pair_reg;
        tx_pair_valid_next = tx_pair_valid_reg;
        tx_out_next = tx_out_reg;
        tx_upd_next = 1'b0;
        if (!power_reg.dac_en) begin
            // Stored words lost while the DACs are off
            tx_i_valid_next = 1'b0;
            tx_pair_valid_next = 1'b0;
            if (!power_reg.ref_en) begin
                tx_out_next = {iqafe_pkg::TX_MIDSCALE, iqafe_pkg::TX_MIDSCALE};
            end
        end else if (conv_fall) begin
            tx_i_hold_next = tx_bus_s; // I on falling edge
            tx_i_valid_next = 1'b1;
        end else if (conv_rise) begin
            if (tx_pair_valid_reg) begin
                tx_out_next = tx_pair_reg; // Both outputs together
                tx_upd_next = 1'b1;
            end
            tx_pair_next = {tx_i_hold_reg, tx_bus_s}; // Q on rising edge
            tx_pair_valid_next = tx_i_valid_reg;
            tx_i_valid_next = 1'b0;
        end
    end

    // Transmit registers
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tx_i_hold_reg <= iqafe_pkg::TX_MIDSCALE;
            tx_i_valid_reg <= 1'b0;
            tx_pair_reg <= {iqafe_pkg::TX_MIDSCALE, iqafe_pkg::TX_MIDSCALE};
            tx_pair_valid_reg <= 1'b0;
            tx_out_reg <= {iqafe_pkg::TX_MIDSCALE, iqafe_pkg::TX_MIDSCALE};
            tx_upd_reg <= 1'b0;
        end else begin
            tx_i_hold_reg <= tx_i_hold_next;
            tx_i_valid_reg <= tx_i_valid_next;
            tx_pair_reg <= tx_pair_next;
            tx_pair_valid_reg <= tx_pair_valid_next;
            tx_out_reg <= tx_out_next;
            tx_upd_reg <= tx_upd_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flops

    // Receive bus and its drive enable
    assign rx_out_bus = rx_out_reg;
    assign rx_out_oe = rx_oe_reg;

    // Converter codes and their update pulse
    assign tx_out = tx_out_reg;
    assign tx_update = tx_upd_reg;

    // Accepted mode word and section enables
    assign mode_word = mode_word_reg;
    assign power = power_reg;

endmodule : iqafe_port

`default_nettype wire

// ==== tb/iqafe_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module iqafe_monitor (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic conv_clk,
    input wire logic [7:0] rx_i_channel,
    input wire logic [7:0] rx_q_channel,
    input wire logic [7:0] rx_out_bus,
    input wire logic rx_out_oe,
    input wire logic [9:0] tx_in_bus,
    input wire iqafe_pkg::iqafe_tx_pair_s tx_out,
    input wire logic tx_update,
    input wire logic ser_clk,
    input wire logic ser_cs_n,
    input wire logic ser_din,
    input wire logic [7:0] mode_word,
    input wire iqafe_pkg::iqafe_power_s power
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////
    logic [3:0] cs_gap_reg;
    logic [3:0] cs_gap_next;
    // Cycles since chip select was last low, saturating
    always_comb begin
        cs_gap_next = (cs_gap_reg == 4'hF) ? cs_gap_reg : cs_gap_reg + 4'h1;
        if (!ser_cs_n) begin
            cs_gap_next = 4'h0;
        end
    end
    // Register the gap count
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cs_gap_reg <= 4'hF;
        end else begin
            cs_gap_reg <= cs_gap_next;
        end
    end
    // Expected section enables per mode code
    function automatic logic [3:0] pw(input logic [2:0] m);
        case (m)
            3'h1: pw = 4'hC;
            3'h2: pw = 4'hE;
            3'h3: pw = 4'hD;
            3'h4: pw = 4'hF;
            3'h5: pw = 4'h8;
            default: pw = 4'h0;
        endcase
    endfunction : pw
    ////////////////////////////////////////////////////////////////
    // Conversion rise or any edge within the last five cycles
    sequence conv_rise_s;
        $past(conv_clk, 1) && !$past(conv_clk, 5);
    endsequence
    sequence conv_edge_s;
        $past(conv_clk, 1) != $past(conv_clk, 5);
    endsequence
    a_mode_legal: assert property (
        mode_word[2:0] <= 3'h5) else $error("illegal mode held");
    a_power_decode: assert property (
        $stable(mode_word)[*2] |-> power == pw(mode_word[2:0])) else $error("power decode");
    a_mode_serial: assert property (
        $changed(mode_word) |-> cs_gap_reg < 4'h8) else $error("mode changed unselected");
    a_oe_follow: assert property (
        $stable(power.adc_en)[*2] |-> rx_out_oe == power.adc_en) else $error("oe mismatch");
    a_upd_pulse: assert property (
        tx_update |=> !tx_update) else $error("update not a pulse");
    a_upd_rise: assert property (
        tx_update |-> conv_rise_s) else $error("update without rise");
    a_tx_hold: assert property (
        $changed(tx_out) && power.dac_en && $past(power.dac_en) |-> tx_update)
        else $error("dac changed without update");
    a_rx_edge: assert property (
        $changed(rx_out_bus) && rx_out_oe && $past(rx_out_oe) |-> conv_edge_s)
        else $error("rx bus changed off edge");
endmodule : iqafe_monitor
`default_nettype wire

// ==== tb/iqafe_ctrl_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module iqafe_ctrl_model (
    input wire logic mclk,
    output logic conv_clk,
    output logic [9:0] tx_in_bus,
    output logic ser_clk,
    output logic ser_cs_n,
    output logic ser_din
);
    // Idle pin levels, transmit bus parked low
    initial begin
        conv_clk = 1'b1;
        tx_in_bus = 10'h000;
        ser_clk = 1'b0;
        ser_cs_n = 1'b1;
        ser_din = 1'b1;
    end
    // Half conversion period of 4 mclk; word held across its edge
    task automatic conv_half(input logic [9:0] w);
        repeat (2) @(negedge mclk);
        tx_in_bus = w;
        repeat (2) @(negedge mclk);
        conv_clk = ~conv_clk;
    endtask : conv_half
    // Serial write, MSB first; fewer than 8 bits aborts
    task automatic ser_write(input logic [7:0] b, input int nbits);
        @(negedge mclk);
        ser_cs_n = 1'b0;
        for (int i = 7; i > 7 - nbits; i--) begin
            @(negedge mclk);
            ser_din = b[i];
            repeat (2) @(negedge mclk);
            ser_clk = 1'b1;
            repeat (2) @(negedge mclk);
            ser_clk = 1'b0;
        end
        @(negedge mclk);
        ser_cs_n = 1'b1;
        ser_din = ~ser_din; // Released line shows no stale bit
        repeat (6) @(negedge mclk);
    endtask : ser_write
endmodule : iqafe_ctrl_model
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic mclk, arst_n, conv_clk, ser_clk, ser_cs_n, ser_din, rx_out_oe, tx_update;
    logic [7:0] rx_i_channel, rx_q_channel, rx_out_bus, mode_word;
    logic [9:0] tx_in_bus;
    logic [2:0] m;
    iqafe_pkg::iqafe_tx_pair_s tx_out;
    iqafe_pkg::iqafe_power_s power;
    logic [3:0] pexp [0:5] = '{4'h0, 4'hC, 4'hE, 4'hD, 4'hF, 4'h8};
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    int n_upd = 0;
    iqafe_port dut (.mclk, .arst_n, .conv_clk, .rx_i_channel, .rx_q_channel, .rx_out_bus,
        .rx_out_oe, .tx_in_bus, .tx_out, .tx_update, .ser_clk, .ser_cs_n, .ser_din,
        .mode_word, .power);
    iqafe_ctrl_model ctl (.mclk, .conv_clk, .tx_in_bus, .ser_clk, .ser_cs_n, .ser_din);
    ////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Counts and verdict
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    // 100 ns clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Count update pulses away from the launching edge
    always @(negedge mclk) begin
        if (tx_update) begin
            n_upd++;
        end
    end
    // Hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        arst_n = 1'b0;
        rx_i_channel = 8'h00;
        rx_q_channel = 8'h00;
        repeat (5) @(negedge mclk);
        arst_n = 1'b1;
        check(rx_out_bus, 8'h80);
        check(rx_out_oe, 1'b0);
        check(tx_out, 20'h80200);
        check(mode_word, 8'h00);
        check(power, 4'h0);
        // Every mode, upper bits set, shutdown last
        for (int k = 1; k <= 6; k++) begin
            m = 3'(k % 6);
            ctl.ser_write({5'h1A, m}, 8);
            check(mode_word, {5'h1A, m});
            check(power, pexp[m]);
            check(rx_out_oe, m == 3'h2 || m == 3'h4);
        end
        // Undefined codes and an aborted write change nothing
        ctl.ser_write(8'hFE, 8);
        ctl.ser_write(8'h06, 8);
        check(mode_word, 8'hD0);
        ctl.ser_write(8'h04, 4);
        check(mode_word, 8'hD0);
        check(power, 4'h0);
        // Transceive streaming: fall then rise per iteration
        ctl.ser_write(8'h04, 8);
        for (int j = 0; j < 14; j++) begin
            ctl.conv_half(10'(10'h3FE + j));
            if (j >= 6) check(rx_out_bus, 8'(8'h7E + j - 6) ^ 8'h80);
            if (j >= 2) check(tx_out, {10'(10'h3FE + j - 2), 10'(10'h1FF + j - 2)});
            ctl.conv_half(10'(10'h1FF + j));
            rx_i_channel = 8'(8'h7E + j);
            rx_q_channel = 8'(8'hFE + j);
            if (j >= 6) check(rx_out_bus, 8'(8'hFE + j - 6) ^ 8'h80);
        end
        // Tri-state in transmit, last word on resume
        ctl.ser_write(8'h03, 8);
        check(rx_out_oe, 1'b0);
        check(n_upd, 32'hD);
        check(tx_out, {10'h00A, 10'h20B});
        ctl.ser_write(8'h04, 8);
        check(rx_out_oe, 1'b1);
        check(rx_out_bus, 8'h86 ^ 8'h80);
        // Shutdown drops stored words, codes back to midscale
        ctl.ser_write(8'h00, 8);
        check(tx_out, 20'h80200);
        check(rx_out_oe, 1'b0);
        test_done();
    end
endmodule : tb
bind iqafe_port iqafe_monitor mon (.mclk, .arst_n, .conv_clk, .rx_i_channel, .rx_q_channel,
    .rx_out_bus, .rx_out_oe, .tx_in_bus, .tx_out, .tx_update, .ser_clk, .ser_cs_n, .ser_din,
    .mode_word, .power);
`default_nettype wire
